// [hw/pmrs_top.sv]
// APB slave, gain and offset compensation, result register and flags.
// Assumes the filter chain and DMA channel run on clk_sys.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pmrs_top
	import pmrs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Filter chain
	input wire pmrs_pkg::pmrs_sample_t sampleIn,
	output logic convEnable,
	output logic micSampleClock,
	// DMA channel
	output pmrs_pkg::pmrs_dma_t dmaOut,
	input wire logic rxCountZero,
	input wire logic rxBothZero,
	input wire logic rxCountWritten,
	// Interrupt
	output logic irqOut
);
	import pmrs_pkg::*;

	// ==========================================================
	// Bus decode
	logic wrEn;
	logic rdEn;
	logic hit;
	logic guardBlock;
	assign pready = 1'b1;
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	always_comb
	begin
		case (paddr)
			OFS_CONTROL, OFS_MODE, OFS_RESULT, OFS_IRQ_EN, OFS_IRQ_DIS, OFS_IRQ_MASK,
			OFS_IRQ_STAT, OFS_DSP_A, OFS_DSP_B, OFS_GUARD_MODE, OFS_GUARD_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !hit;

	// ==========================================================
	// Soft reset: a one-cycle pulse that returns every register to its reset value
	logic softRst_q;
	logic softRst_d;
	assign softRst_d = wrEn && paddr == OFS_CONTROL && pwdata[BIT_SOFT_RESET]; // [R18]
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			softRst_q <= 1'b0;
		else
			softRst_q <= softRst_d;
	end

	// ==========================================================
	// Configuration registers
	logic convEn_q, convEn_d;
	logic [31:0] mode_q, mode_d;
	logic [31:0] dspA_q, dspA_d;
	logic [31:0] dspB_q, dspB_d;
	logic guardEn_q, guardEn_d;
	logic [4:0] mask_q, mask_d;
	logic violation_q, violation_d;
	logic [7:0] vsrc_q, vsrc_d;
	logic protTarget;
	assign protTarget = paddr == OFS_MODE || paddr == OFS_DSP_A || paddr == OFS_DSP_B;
	assign guardBlock = wrEn && protTarget && guardEn_q; // [R15]
	always_comb
	begin
		convEn_d = convEn_q;
		mode_d = mode_q;
		dspA_d = dspA_q;
		dspB_d = dspB_q;
		guardEn_d = guardEn_q;
		mask_d = mask_q;
		violation_d = violation_q;
		vsrc_d = vsrc_q;
		if (rdEn && paddr == OFS_GUARD_STAT)
			violation_d = 1'b0; // [R17]
		if (wrEn && !guardBlock)
		begin
			case (paddr)
				OFS_CONTROL: convEn_d = pwdata[BIT_CONV_ENABLE]; // [R19]
				OFS_MODE: mode_d = pwdata;
				OFS_DSP_A: dspA_d = pwdata;
				OFS_DSP_B: dspB_d = pwdata;
				OFS_GUARD_MODE:
				begin
					if (pwdata[31:KEY_LO] == GUARD_KEY)
						guardEn_d = pwdata[BIT_GUARD_EN];
				end
				OFS_IRQ_EN: mask_d = mask_q | (pwdata[IRQ_HI:IRQ_LO] & IRQ_VALID); // [R21]
				OFS_IRQ_DIS: mask_d = mask_q & ~pwdata[IRQ_HI:IRQ_LO];
				default: ;
			endcase
		end
		if (guardBlock)
		begin
			violation_d = 1'b1; // [R16]
			vsrc_d = paddr;
		end
		if (softRst_q)
		begin
			convEn_d = 1'b0; // [R18]
			mode_d = RST_MODE;
			dspA_d = RST_DSP_A;
			dspB_d = RST_DSP_B;
			guardEn_d = 1'b0;
			mask_d = '0;
			violation_d = 1'b0;
			vsrc_d = '0;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			convEn_q <= 1'b0;
			mode_q <= RST_MODE;
			dspA_q <= RST_DSP_A;
			dspB_q <= RST_DSP_B;
			guardEn_q <= 1'b0;
			mask_q <= '0;
			violation_q <= 1'b0;
			vsrc_q <= '0;
		end
		else
		begin
			convEn_q <= convEn_d;
			mode_q <= mode_d;
			dspA_q <= dspA_d;
			dspB_q <= dspB_d;
			guardEn_q <= guardEn_d;
			mask_q <= mask_d;
			violation_q <= violation_d;
			vsrc_q <= vsrc_d;
		end
	end
	assign convEnable = convEn_q;

	// ==========================================================
	// Sample clock divider: toggles every prescaler+1 cycles
	logic [6:0] divCnt_q, divCnt_d;
	logic sclk_q, sclk_d;
	always_comb
	begin
		divCnt_d = divCnt_q;
		sclk_d = sclk_q;
		if (!convEn_q || softRst_q)
		begin
			divCnt_d = '0;
			sclk_d = 1'b0;
		end
		else if (divCnt_q >= mode_q[PRESC_HI:PRESC_LO])
		begin
			divCnt_d = '0; // [R20]
			sclk_d = !sclk_q;
		end
		else
			divCnt_d = divCnt_q + 7'h01;
	end
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			divCnt_q <= '0;
			sclk_q <= 1'b0;
		end
		else
		begin
			divCnt_q <= divCnt_d;
			sclk_q <= sclk_d;
		end
	end
	assign micSampleClock = sclk_q;

	// ==========================================================
	// Compensation, one registered stage
	// Full product is kept wide; the 32 MSBs of the 40-bit signed
	// product feed the shifts, so low bits are lost by design.
	logic signed [24:0] corrected;
	logic signed [40:0] product;
	logic signed [31:0] kept;
	logic signed [31:0] scaled;
	logic signed [31:0] shifted;
	logic signed [31:0] clamped;
	logic signed [31:0] result;
	logic is32;
	assign corrected = 25'(sampleIn.data) + 25'($signed({dspB_q[31:OFFSET_LO], 8'h00})); // [R1] [R2]
	assign product = 41'(corrected) * $signed({26'h0, dspB_q[14:GAIN_LO]}); // [R3]
	// Taking the 32 MSBs already is the fixed shift by eight
	assign kept = product[FIXED_SHIFT +: 32]; // [R3] [R4]
	assign scaled = kept >>> dspA_q[SCALE_LO +: 4]; // [R4]
	assign shifted = scaled >>> dspA_q[SHIFT_LO +: 4]; // [R5]
	assign is32 = dspA_q[BIT_SIZE]; // [R22]
	always_comb
	begin
		if (shifted > SAT_POS)
			clamped = SAT_POS; // [R7]
		else if (shifted < SAT_NEG)
			clamped = SAT_NEG;
		else
			clamped = shifted;
		if (is32)
			result = scaled; // [R6]
		else
			result = {16'h0000, clamped[15:0]}; // [R7] [R8]
	end

	// ==========================================================
	// Result register, status flags and DMA request
	logic [31:0] data_q, data_d;
	logic dataReady_q, dataReady_d;
	logic overrun_q, overrun_d;
	logic end_of_receive_flag_q, end_of_receive_flag_d;
	logic dmaReq_q, dmaReq_d;
	logic conv;
	logic [4:0] status;
	assign conv = sampleIn.valid && convEn_q;
	always_comb
	begin
		data_d = data_q;
		dataReady_d = dataReady_q;
		overrun_d = overrun_q;
		end_of_receive_flag_d = end_of_receive_flag_q;
		dmaReq_d = 1'b0;
		if (rdEn && paddr == OFS_RESULT)
			dataReady_d = 1'b0; // [R11]
		if (rdEn && paddr == OFS_IRQ_STAT)
			overrun_d = 1'b0; // [R13]
		if (rxCountWritten)
			end_of_receive_flag_d = 1'b0;
		if (rxCountZero)
			end_of_receive_flag_d = 1'b1; // [R23]
		// A sample in the cycle of the clearing read still counts as overrun
		if (conv && dataReady_q)
			overrun_d = 1'b1; // [R12]
		else if (conv)
		begin
			data_d = result; // [R9]
			dataReady_d = 1'b1; // [R9]
			dmaReq_d = 1'b1; // [R10] [R14]
		end
		if (softRst_q)
		begin
			data_d = '0;
			dataReady_d = 1'b0;
			overrun_d = 1'b0;
			end_of_receive_flag_d = 1'b0;
			dmaReq_d = 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			data_q <= '0;
			dataReady_q <= 1'b0;
			overrun_q <= 1'b0;
			end_of_receive_flag_q <= 1'b0;
			dmaReq_q <= 1'b0;
		end
		else
		begin
			data_q <= data_d;
			dataReady_q <= dataReady_d;
			overrun_q <= overrun_d;
			end_of_receive_flag_q <= end_of_receive_flag_d;
			dmaReq_q <= dmaReq_d;
		end
	end
	// One assignment for the whole carrier keeps a single driver
	assign dmaOut = '{req: dmaReq_q, data: data_q[15:0]}; // [R14]
	assign status = {rxBothZero, end_of_receive_flag_q, 1'b0, overrun_q, dataReady_q};
	assign irqOut = |(status & mask_q); // [R10] [R24]

	// ==========================================================
	// Read mux
	always_comb
	begin
		prdata = '0;
		if (rdEn)
		begin
			case (paddr)
				OFS_CONTROL: prdata[BIT_CONV_ENABLE] = convEn_q; // [R18]
				OFS_MODE: prdata = mode_q;
				OFS_RESULT: prdata = data_q;
				OFS_IRQ_MASK: prdata[IRQ_HI:IRQ_LO] = mask_q;
				OFS_IRQ_STAT: prdata[IRQ_HI:IRQ_LO] = status;
				OFS_DSP_A: prdata = dspA_q;
				OFS_DSP_B: prdata = dspB_q;
				OFS_GUARD_MODE: prdata[BIT_GUARD_EN] = guardEn_q;
				OFS_GUARD_STAT: prdata = {16'h0000, vsrc_q, 7'h00, violation_q};
				default: prdata = '0;
			endcase
		end
	end
endmodule
`default_nettype wire

// [hw/pmrs_pkg.sv]
// Constants and carriers for the PDM microphone result stage.
// Assumes an APB master on clk_sys and a filter chain on the same clock.
//
// Overview of operation
// R1: Input is signed 24-bit filter sample
// R2: Offset times 256 added to sample
// R3: Unsigned 15-bit gain, keep 32 MSBs
// R4: Shift right by scale plus eight
// R5: Second shift by shift amount
// R6: 32-bit mode skips shift, full result
// R7: 16-bit mode shifts, clamps to 32767
// R8: Reset settings give 16-bit result
// R9: Completed conversion stored, data-ready set
// R10: Data-ready rise requests DMA, may interrupt
// R11: Result read clears data-ready, holds value
// R12: Conversion while ready sets overrun, discards
// R13: Status read clears overrun
// R14: DMA moves right-aligned half-word per store
// R15: Guard blocks mode and DSP writes
// R16: Blocked write flags violation, records register
// R17: Guard status read clears violation flag
// R18: Soft reset bit resets all, reads zero
// R19: Conversion enable starts and stops conversions
// R20: Sample clock is clk over 2(prescaler+1)
// R21: Enable write one sets, zero ignored
// R22: Size bit selects 16 or 32 bits
// R23: End-of-receive set when counter reaches zero
// R24: Interrupt when flag set and masked in
package pmrs_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h18;
	localparam logic [7:0] OFS_IRQ_DIS = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_DSP_A = 8'h58;
	localparam logic [7:0] OFS_DSP_B = 8'h5c;
	localparam logic [7:0] OFS_GUARD_MODE = 8'he4;
	localparam logic [7:0] OFS_GUARD_STAT = 8'he8;
	// ==========================================================
	// Reset values
	localparam logic [31:0] RST_MODE = 32'h00f00000;
	localparam logic [31:0] RST_DSP_A = 32'h00000000;
	localparam logic [31:0] RST_DSP_B = 32'h00000001;
	// ==========================================================
	// Field positions
	localparam int BIT_SOFT_RESET = 0;
	localparam int BIT_CONV_ENABLE = 4;
	localparam int PRESC_LO = 8;
	localparam int PRESC_HI = 14;
	localparam int IRQ_LO = 24;
	localparam int IRQ_HI = 28;
	localparam int BIT_DATA_READY = 24;
	localparam int BIT_OVERRUN = 25;
	localparam int BIT_END_RX = 27;
	localparam int BIT_RX_FULL = 28;
	localparam logic [4:0] IRQ_VALID = 5'h1b;
	localparam int BIT_SIZE = 3;
	localparam int SCALE_LO = 8;
	localparam int SHIFT_LO = 12;
	localparam int GAIN_LO = 0;
	localparam int OFFSET_LO = 16;
	localparam int BIT_GUARD_EN = 0;
	localparam int KEY_LO = 8;
	localparam logic [23:0] GUARD_KEY = 24'h414443;
	localparam int VSRC_LO = 8;
	// ==========================================================
	// Arithmetic constants
	localparam int FIXED_SHIFT = 8;
	localparam logic signed [31:0] SAT_POS = 32'sh00007fff;
	localparam logic signed [31:0] SAT_NEG = -32'sh00007fff;

	// Filter chain sample with its strobe
	typedef struct packed {
		logic valid;
		logic signed [23:0] data;
	} pmrs_sample_t;

	// DMA request with the half-word it carries
	typedef struct packed {
		logic req;
		logic [15:0] data;
	} pmrs_dma_t;
endpackage

// [verification/pmrs_monitor.sv]
// Checker on the result stage top ports.
// Assumes one clock domain and rstn resets all state.
`timescale 1ns/1ns
`default_nettype none
module pmrs_monitor
	import pmrs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Stream and DMA
	input wire pmrs_pkg::pmrs_sample_t sampleIn,
	input wire logic convEnable,
	input wire logic micSampleClock,
	input wire pmrs_pkg::pmrs_dma_t dmaOut,
	input wire logic rxCountZero,
	input wire logic rxBothZero,
	input wire logic rxCountWritten,
	input wire logic irqOut
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	logic rd;
	logic wrCtrl;
	assign rd = psel && penable && !pwrite;
	assign wrCtrl = psel && penable && pwrite && paddr == OFS_CONTROL;
	// ==========
	// Assertions
	AST_DMA_PULSE: assert property (dmaOut.req |=> !dmaOut.req)
		else $error("dma request too long");
	AST_DMA_CAUSE: assert property (dmaOut.req |-> $past(sampleIn.valid))
		else $error("dma request without sample");
	AST_CLK_OFF: assert property ((!convEnable) [*3] |-> !micSampleClock)
		else $error("sample clock runs while disabled");
	AST_ENABLE: assert property (wrCtrl && !pwdata[0] |=> convEnable == $past(pwdata[4]))
		else $error("enable bit not taken");
	AST_SOFT_RESET_BIT: assert property (wrCtrl && pwdata[0] |-> ##2 !convEnable)
		else $error("soft reset left enable set");
	AST_CTRL_ZERO: assert property (rd && paddr == OFS_CONTROL |-> !prdata[0])
		else $error("soft reset bit reads one");
	AST_OVERRUN_FLAG_CLR: assert property ((rd && paddr == OFS_IRQ_STAT && !sampleIn.valid) ##1
		(!sampleIn.valid) [*2] ##1 (rd && paddr == OFS_IRQ_STAT) |-> !prdata[25])
		else $error("overrun kept after status read");
	AST_GUARD_CLR: assert property ((rd && paddr == OFS_GUARD_STAT) ##3
		(rd && paddr == OFS_GUARD_STAT) |-> !prdata[0])
		else $error("violation kept after read");
	cover property (dmaOut.req);
	cover property (psel && penable && pslverr);
	cover property ($rose(micSampleClock));
endmodule
`default_nettype wire

// [verification/pmrs_dma_model.sv]
// DMA channel model: stores each half-word and counts transfers down.
// Assumes single-cycle requests on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module pmrs_dma_model
	import pmrs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Device side
	input wire pmrs_pkg::pmrs_dma_t dmaOut,
	output logic rxCountZero,
	output logic rxBothZero,
	output logic rxCountWritten,
	// Bench side
	input wire logic reload,
	input wire logic [3:0] loadCount,
	output logic [15:0] lastWord,
	output logic [7:0] nWords
);
	logic [3:0] cnt_q;
	// Nonzero after reset so a pending buffer is modelled
	assign rxBothZero = cnt_q == 4'h0;
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= 4'hf;
			rxCountZero <= 1'b0;
			rxCountWritten <= 1'b0;
			lastWord <= 16'h0;
			nWords <= 8'h0;
		end
		else
		begin
			rxCountWritten <= reload;
			rxCountZero <= dmaOut.req && cnt_q == 4'h1;
			if (reload)
				cnt_q <= loadCount;
			else if (dmaOut.req && cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			if (dmaOut.req)
			begin
				lastWord <= dmaOut.data;
				nWords <= nWords + 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/pdm_mic_result_stage_bench.sv]
// Bench for the result stage: APB tasks and a DMA channel model.
// Assumes pmrs_top, pmrs_monitor and pmrs_dma_model are compiled.
`timescale 1ns/1ns
`default_nettype none
module pdm_mic_result_stage_bench;
	import pmrs_pkg::*;
	logic clk_sys, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, convEnable, micSampleClock, irqOut, slv;
	logic rxCountZero, rxBothZero, rxCountWritten, reload = 1'b0;
	logic [7:0] paddr = 8'h0, nWords;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic [15:0] lastWord;
	pmrs_sample_t sampleIn = '0;
	pmrs_dma_t dmaOut;
	int n_mismatch = 0, num_checks = 0;
	time t0;
	logic [31:0] tA[5] = '{32'h0, 32'h0, 32'h8, 32'h2300, 32'hf008};
	logic [31:0] tB[5] = '{32'h1, 32'h7fff, 32'h7fff, 32'hffff0010, 32'h1};
	logic [23:0] tD[5] = '{24'h123456, 24'h800000, 24'h400000, 24'h001000, 24'h7fffff};
	pmrs_top DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sampleIn(sampleIn), .convEnable(convEnable),
		.micSampleClock(micSampleClock), .dmaOut(dmaOut), .rxCountZero(rxCountZero),
		.rxBothZero(rxBothZero), .rxCountWritten(rxCountWritten), .irqOut(irqOut));
	pmrs_dma_model dma (.clk_sys(clk_sys), .rstn(rstn), .dmaOut(dmaOut),
		.rxCountZero(rxCountZero), .rxBothZero(rxBothZero), .rxCountWritten(rxCountWritten),
		.reload(reload), .loadCount(4'h5), .lastWord(lastWord), .nWords(nWords));
	task automatic tally_and_finish();
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdv = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(what, exp, rdv);
	endtask
	task automatic smp(input logic [23:0] d);
		@(posedge clk_sys);
		sampleIn <= '{1'b1, d};
		@(posedge clk_sys);
		sampleIn.valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	// Gain, offset, scale and shift as the formula gives them
	function automatic logic [31:0] calc(input logic [31:0] a, b, input logic [23:0] d);
		longint p;
		p = (longint'($signed(d)) + (longint'($signed(b[31:16])) <<< 8)) * longint'(b[14:0]);
		p = p >>> (8 + a[11:8]);
		if (a[BIT_SIZE])
			return p[31:0];
		p = p >>> a[15:12];
		if (p > longint'(SAT_POS))
			p = longint'(SAT_POS);
		if (p < longint'(SAT_NEG))
			p = longint'(SAT_NEG);
		return {16'h0, p[15:0]};
	endfunction
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		rdc("mode", OFS_MODE, RST_MODE);
		rdc("dspa", OFS_DSP_A, RST_DSP_A);
		rdc("dspb", OFS_DSP_B, RST_DSP_B);
		rdc("status", OFS_IRQ_STAT, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		cmp("slverr", 32'h1, {31'h0, slv});
		reload <= 1'b1;
		@(posedge clk_sys);
		reload <= 1'b0;
		apb(1'b1, OFS_CONTROL, 32'h10);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, OFS_DSP_A, tA[i]);
			apb(1'b1, OFS_DSP_B, tB[i]);
			smp(tD[i]);
			cmp("dma", calc(tA[i], tB[i], tD[i]) & 32'h0000ffff, {16'h0, lastWord});
			rdc("result", OFS_RESULT, calc(tA[i], tB[i], tD[i]));
		end
		cmp("words", 32'h5, {24'h0, nWords});
		rdc("status", OFS_IRQ_STAT, 32'h18000000);
		apb(1'b1, OFS_IRQ_EN, 32'h09000000);
		apb(1'b1, OFS_IRQ_EN, 32'h0);
		rdc("mask", OFS_IRQ_MASK, 32'h09000000);
		@(negedge clk_sys);
		cmp("irq", 32'h1, {31'h0, irqOut});
		apb(1'b1, OFS_IRQ_DIS, 32'h08000000);
		// The mask settles only after the access edge
		@(negedge clk_sys);
		cmp("irq", 32'h0, {31'h0, irqOut});
		smp(24'h000100);
		smp(24'h000200);
		cmp("irq", 32'h1, {31'h0, irqOut});
		rdc("status", OFS_IRQ_STAT, 32'h1b000000);
		rdc("status", OFS_IRQ_STAT, 32'h19000000);
		rdc("result", OFS_RESULT, 32'h1);
		rdc("status", OFS_IRQ_STAT, 32'h18000000);
		apb(1'b1, OFS_GUARD_MODE, {GUARD_KEY, 8'h01});
		apb(1'b1, OFS_DSP_A, 32'h0);
		rdc("dspa", OFS_DSP_A, 32'hf008);
		rdc("guard", OFS_GUARD_STAT, {16'h0, OFS_DSP_A, 8'h01});
		rdc("guard", OFS_GUARD_STAT, {16'h0, OFS_DSP_A, 8'h00});
		apb(1'b1, OFS_GUARD_MODE, 32'h0);
		apb(1'b1, OFS_MODE, 32'h200);
		rdc("mode", OFS_MODE, RST_MODE);
		apb(1'b1, OFS_GUARD_MODE, {GUARD_KEY, 8'h00});
		apb(1'b1, OFS_MODE, 32'h00f00200);
		@(posedge micSampleClock);
		t0 = $time;
		@(posedge micSampleClock);
		cmp("period", 32'h18, 32'($time - t0));
		apb(1'b1, OFS_CONTROL, 32'h1);
		repeat (2) @(posedge clk_sys);
		rdc("mode", OFS_MODE, RST_MODE);
		rdc("control", OFS_CONTROL, 32'h0);
		smp(24'h000100);
		cmp("words", 32'h6, {24'h0, nWords});
		tally_and_finish();
	end
endmodule
bind pmrs_top pmrs_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sampleIn(sampleIn), .convEnable(convEnable),
	.micSampleClock(micSampleClock), .dmaOut(dmaOut), .rxCountZero(rxCountZero),
	.rxBothZero(rxBothZero), .rxCountWritten(rxCountWritten), .irqOut(irqOut));
`default_nettype wire
